/* File: rtl/temp_regs_pkg.sv */
package temp_regs_pkg;

    // register addresses on the serial port
    localparam logic [6:0] ADDR_TEMP_CTL    = 7'h4E;
    localparam logic [6:0] ADDR_TEMP_RESULT = 7'h4F;
    localparam logic [6:0] ADDR_LNA_SEL     = 7'h58;
    localparam logic [6:0] ADDR_FADING_SEL  = 7'h6F;
    localparam logic [6:0] ADDR_AFC_OFFSET  = 7'h71;

    // control register field positions and fixed read values
    localparam int         CTL_TRIG_BIT   = 3;
    localparam int         CTL_ACTIVE_BIT = 2;
    localparam logic [1:0] CTL_LOW_BITS   = 2'h1;

    // tuning codes
    localparam logic [7:0] LNA_NORMAL      = 8'h1B;
    localparam logic [7:0] LNA_HIGH        = 8'h2D;
    localparam logic [7:0] DAGC_NORMAL     = 8'h00;
    localparam logic [7:0] DAGC_LOW_IDX    = 8'h10;
    localparam logic [7:0] DAGC_NO_LOW_IDX = 8'h30;

    // values after reset
    localparam logic [7:0]  LNA_RST    = LNA_NORMAL;
    localparam logic [7:0]  DAGC_RST   = DAGC_NORMAL;
    localparam logic [7:0]  AFC_RST    = 8'h00;
    localparam logic [7:0]  RESULT_RST = 8'h00;
    localparam logic [15:0] CNT_RST    = 16'h0000;
    localparam logic [3:0]  BITS_RST   = 4'h0;

    // frequency step of the low-index offset, in Hz
    localparam logic [16:0] AFC_STEP_HZ = 17'h0_01E8;

    // conversion time
    localparam int CONV_TIME_US = 100;
    localparam int CORE_CLK_MHZ = 100;
    localparam int CONV_CYCLES  = CONV_TIME_US * CORE_CLK_MHZ;

    // serial frame bit counts
    localparam logic [3:0] BIT_ADDR_LAST  = 4'h7;
    localparam logic [3:0] BIT_FIRST_DATA = 4'h8;
    localparam logic [3:0] BIT_DATA_LAST  = 4'hF;

    typedef struct packed {
        logic [7:0] lna;
        logic [7:0] dagc;
        logic [7:0] afc;
    } tune_cfg_t;

    typedef struct packed {
        logic       wnr;
        logic [6:0] addr;
    } spi_cmd_t;

    typedef enum logic [0:0] {
        CONV_IDLE = 1'b0,
        CONV_RUN  = 1'b1
    } conv_state_t;

endpackage : temp_regs_pkg

/* File: rtl/bit_sync.sv */
`timescale 1ns/100ps
module bit_sync (
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    input  wire logic i_async,
    output logic      o_sync
);
    logic meta_q;

    // two-stage synchroniser; only the second stage is read outside
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_q <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule : bit_sync

/* File: rtl/temp_sensor_test_regs_reset.sv */
`timescale 1ns/100ps
module temp_sensor_test_regs_reset #(
    parameter int unsigned P_CONV_CYCLES = temp_regs_pkg::CONV_CYCLES
) (
    input  wire logic                     i_core_clk,
    input  wire logic                     i_reset_n,
    input  wire logic                     i_spi_sck,
    input  wire logic                     i_spi_nss_n,
    input  wire logic                     i_spi_mosi,
    output logic                          o_spi_miso,
    output logic                          o_spi_miso_oe_n,
    input  wire logic [7:0]               i_sensor_code,
    input  wire logic                     i_low_index_afc_enable,
    output logic                          o_temp_conv_active,
    output logic                          o_rx_inhibit,
    output temp_regs_pkg::tune_cfg_t      o_tune_cfg,
    output logic                          o_high_sensitivity,
    output logic                          o_fading_improved,
    output logic [16:0]                   o_low_index_freq_offset_hz
);
    import temp_regs_pkg::*;

    // ---------------- link side, on the serial clock ----------------
    logic [3:0]  bit_cnt_q;
    logic [6:0]  shift_in_q;
    spi_cmd_t    cmd_q;
    logic [7:0]  out_q;
    logic [7:0]  wr_data;
    logic        wr_now;
    tune_cfg_t   cfg_sck_q;
    logic        cfg_tgl_q;
    logic        trig_tgl_q;
    logic        active_sck;
    logic        done_sck;
    logic        done_prev_q;
    logic [7:0]  result_sck_q;
    logic [7:0]  rd_mux;

    // ---------------- core side ----------------
    conv_state_t state_q;
    logic [15:0] conv_cnt_q;
    logic [7:0]  result_q;
    logic        done_tgl_q;
    logic        trig_core;
    logic        trig_prev_q;
    logic        trig_edge;
    logic        cfg_core;
    logic        cfg_prev_q;
    tune_cfg_t   cfg_q;

    assign wr_data = {shift_in_q, i_spi_mosi};
    assign wr_now  = (bit_cnt_q == BIT_DATA_LAST) && cmd_q.wnr;

    // frame bit counter, command byte capture and burst address step
    always_ff @(posedge i_spi_sck or posedge i_spi_nss_n) begin
        if (i_spi_nss_n) begin
            bit_cnt_q  <= BITS_RST;
            shift_in_q <= 7'h00;
            cmd_q      <= '0;
        end else begin
            shift_in_q <= wr_data[6:0];
            if (bit_cnt_q == BIT_DATA_LAST) begin
                bit_cnt_q  <= BIT_FIRST_DATA;
                cmd_q.addr <= cmd_q.addr + 7'h01;
            end else begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            if (bit_cnt_q == BIT_ADDR_LAST) begin
                cmd_q <= wr_data;
            end
        end
    end

    // writable registers; each tuning-register write, or a control write with the trigger bit set, flips a toggle for the core
    always_ff @(posedge i_spi_sck or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cfg_sck_q  <= '{lna: LNA_RST, dagc: DAGC_RST, afc: AFC_RST};
            cfg_tgl_q  <= 1'b0;
            trig_tgl_q <= 1'b0;
        end else if (wr_now) begin
            case (cmd_q.addr)
                ADDR_TEMP_CTL: begin
                    if (wr_data[CTL_TRIG_BIT]) begin
                        trig_tgl_q <= ~trig_tgl_q;
                    end
                end
                ADDR_LNA_SEL: begin
                    cfg_sck_q.lna <= wr_data;
                    cfg_tgl_q     <= ~cfg_tgl_q;
                end
                ADDR_FADING_SEL: begin
                    cfg_sck_q.dagc <= wr_data;
                    cfg_tgl_q      <= ~cfg_tgl_q;
                end
                ADDR_AFC_OFFSET: begin
                    cfg_sck_q.afc <= wr_data;
                    cfg_tgl_q     <= ~cfg_tgl_q;
                end
                default: begin
                    cfg_tgl_q <= cfg_tgl_q;
                end
            endcase
        end
    end

    bit_sync u_active_sync (
        .i_clk     (i_spi_sck),
        .i_reset_n (i_reset_n),
        .i_async   (state_q == CONV_RUN),
        .o_sync    (active_sck)
    );

    bit_sync u_done_sync (
        .i_clk     (i_spi_sck),
        .i_reset_n (i_reset_n),
        .i_async   (done_tgl_q),
        .o_sync    (done_sck)
    );

    // result word is held stable in the core until the next conversion ends
    always_ff @(posedge i_spi_sck or negedge i_reset_n) begin
        if (!i_reset_n) begin
            done_prev_q  <= 1'b0;
            result_sck_q <= RESULT_RST;
        end else begin
            done_prev_q <= done_sck;
            if (done_sck != done_prev_q) begin
                result_sck_q <= result_q;
            end
        end
    end

    always_comb begin
        case (cmd_q.addr)
            ADDR_TEMP_CTL:    rd_mux = {4'h0, 1'b0, active_sck, CTL_LOW_BITS};
            ADDR_TEMP_RESULT: rd_mux = result_sck_q;
            ADDR_LNA_SEL:     rd_mux = cfg_sck_q.lna;
            ADDR_FADING_SEL:  rd_mux = cfg_sck_q.dagc;
            ADDR_AFC_OFFSET:  rd_mux = cfg_sck_q.afc;
            default:          rd_mux = 8'h00;
        endcase
    end

    // read data loads on the falling edge that opens each data byte
    always_ff @(negedge i_spi_sck or posedge i_spi_nss_n) begin
        if (i_spi_nss_n) begin
            out_q <= 8'h00;
        end else if (bit_cnt_q[3] && (bit_cnt_q[2:0] == 3'h0)) begin
            out_q <= cmd_q.wnr ? 8'h00 : rd_mux;
        end else begin
            out_q <= {out_q[6:0], 1'b0};
        end
    end

    assign o_spi_miso      = out_q[7];
    assign o_spi_miso_oe_n = i_spi_nss_n;

    // ---------------- core domain ----------------
    bit_sync u_trig_sync (
        .i_clk     (i_core_clk),
        .i_reset_n (i_reset_n),
        .i_async   (trig_tgl_q),
        .o_sync    (trig_core)
    );

    bit_sync u_cfg_sync (
        .i_clk     (i_core_clk),
        .i_reset_n (i_reset_n),
        .i_async   (cfg_tgl_q),
        .o_sync    (cfg_core)
    );

    assign trig_edge = trig_core ^ trig_prev_q;

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            trig_prev_q <= 1'b0;
            cfg_prev_q  <= 1'b0;
            cfg_q       <= '{lna: LNA_RST, dagc: DAGC_RST, afc: AFC_RST};
        end else begin
            trig_prev_q <= trig_core;
            cfg_prev_q  <= cfg_core;
            if (cfg_core != cfg_prev_q) begin
                cfg_q <= cfg_sck_q;
            end
        end
    end

    // conversion sequencer; triggers while running are dropped
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q    <= CONV_IDLE;
            conv_cnt_q <= CNT_RST;
        end else begin
            case (state_q)
                CONV_IDLE: begin
                    if (trig_edge) begin
                        state_q    <= CONV_RUN;
                        conv_cnt_q <= 16'(P_CONV_CYCLES - 1);
                    end
                end
                CONV_RUN: begin
                    if (conv_cnt_q == CNT_RST) begin
                        state_q <= CONV_IDLE;
                    end else begin
                        conv_cnt_q <= conv_cnt_q - 16'h0001;
                    end
                end
                default: begin
                    state_q <= CONV_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            result_q   <= RESULT_RST;
            done_tgl_q <= 1'b0;
        end else if ((state_q == CONV_RUN) && (conv_cnt_q == CNT_RST)) begin
            result_q   <= i_sensor_code;
            done_tgl_q <= ~done_tgl_q;
        end
    end

    assign o_temp_conv_active = (state_q == CONV_RUN);
    assign o_rx_inhibit       = (state_q == CONV_RUN);

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_tune_cfg                 <= '{lna: LNA_RST, dagc: DAGC_RST, afc: AFC_RST};
            o_high_sensitivity         <= 1'b0;
            o_fading_improved          <= 1'b0;
            o_low_index_freq_offset_hz <= 17'h0_0000;
        end else begin
            o_tune_cfg         <= cfg_q;
            o_high_sensitivity <= (cfg_q.lna == LNA_HIGH);
            o_fading_improved  <= (cfg_q.dagc == DAGC_LOW_IDX)
                               || (cfg_q.dagc == DAGC_NO_LOW_IDX);
            o_low_index_freq_offset_hz <= i_low_index_afc_enable
                ? 17'({9'h000, cfg_q.afc} * AFC_STEP_HZ) : 17'h0_0000;
        end
    end

    // ---------------- checks ----------------
    a_trig_reads_zero: assert property (@(posedge i_spi_sck) disable iff (!i_reset_n)
        (cmd_q.addr == ADDR_TEMP_CTL) |-> (rd_mux[CTL_TRIG_BIT] == 1'b0 && rd_mux[1:0] == 2'h1))
        else $error("trigger bit or fixed bits read wrong");

    a_trig_starts_conv: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (trig_edge && state_q == CONV_IDLE) |=> (o_temp_conv_active && conv_cnt_q == 16'(P_CONV_CYCLES - 1)))
        else $error("trigger did not start conversion");

    a_active_holds: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (o_temp_conv_active && conv_cnt_q != CNT_RST) |=> o_temp_conv_active)
        else $error("activity flag dropped early");

    a_conv_end: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (o_temp_conv_active && conv_cnt_q == CNT_RST)
        |=> (!o_temp_conv_active && result_q == $past(i_sensor_code) && $changed(done_tgl_q)))
        else $error("conversion end did not store result");

    a_result_stable: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        !o_temp_conv_active |=> $stable(result_q))
        else $error("result changed with no conversion");

    a_busy_ignore: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (trig_edge && o_temp_conv_active && conv_cnt_q != CNT_RST)
        |=> (o_temp_conv_active && conv_cnt_q == $past(conv_cnt_q) - 16'h0001))
        else $error("trigger disturbed running conversion");

    a_lna_decode: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (cfg_q.lna == LNA_HIGH) [*2] |-> o_high_sensitivity)
        else $error("high sensitivity not selected");

    a_fading_decode: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        o_fading_improved |-> ($past(cfg_q.dagc) == DAGC_LOW_IDX || $past(cfg_q.dagc) == DAGC_NO_LOW_IDX))
        else $error("improved margin without matching code");

    a_afc_offset: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        ##1 (o_low_index_freq_offset_hz == ($past(i_low_index_afc_enable)
            ? 17'($past(cfg_q.afc) * 488) : 17'h0_0000)))
        else $error("afc offset wrong");

endmodule : temp_sensor_test_regs_reset

/* File: dv/spi_host_model.sv */
`timescale 1ns/100ps
module spi_host_model (
    output logic      o_sck,
    output logic      o_nss_n,
    output logic      o_mosi,
    input  wire logic i_miso
);

    initial begin
        o_sck   = 1'b0;
        o_nss_n = 1'b1;
        o_mosi  = 1'b0;
    end

    // one frame: command byte then one or two data bytes, msb first, mode 0
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] wdat, input int n_bits,
                        output logic [15:0] rdat);
        logic [23:0] frame;
        frame = {cmd, wdat};
        rdat  = 16'h0000;
        #3.1;
        o_nss_n = 1'b0;
        for (int i = 23; i >= 24 - n_bits; i--) begin
            o_mosi = frame[i];
            #62.5;
            o_sck = 1'b1;
            if (i < 16) begin
                rdat = {rdat[14:0], i_miso};
            end
            #62.5;
            o_sck = 1'b0;
        end
        #62.5;
        o_nss_n = 1'b1;
        // released data line shows the inverse of its last bit
        o_mosi = ~o_mosi;
        #250;
    endtask : xfer

endmodule : spi_host_model

/* File: dv/temp_sensor_test_regs_reset_tb.sv */
`timescale 1ns/100ps
module temp_sensor_test_regs_reset_tb;
    import temp_regs_pkg::*;

    localparam int P_CONV = 1000;

    logic        core_clk;
    logic        reset_n;
    logic        spi_sck;
    logic        spi_nss_n;
    logic        spi_mosi;
    logic        spi_miso;
    logic        miso_oe_n;
    logic [15:0] burst;
    logic [7:0]  sensor_code;
    logic        afc_en;
    logic        conv_active;
    logic        rx_inhibit;
    tune_cfg_t   tune_cfg;
    logic        high_sens;
    logic        fading_imp;
    logic [16:0] offset_hz;
    int          n_errors     = 0;
    int          total_checks = 0;
    int          cycles       = 0;
    int          active_cycles = 0;
    logic [7:0]  codes [5] = '{LNA_HIGH, LNA_NORMAL, DAGC_LOW_IDX, DAGC_NO_LOW_IDX, DAGC_NORMAL};

    temp_sensor_test_regs_reset #(.P_CONV_CYCLES(P_CONV)) i_temp_sensor_test_regs_reset (
        .i_core_clk                 (core_clk),
        .i_reset_n                  (reset_n),
        .i_spi_sck                  (spi_sck),
        .i_spi_nss_n                (spi_nss_n),
        .i_spi_mosi                 (spi_mosi),
        .o_spi_miso                 (spi_miso),
        .o_spi_miso_oe_n            (miso_oe_n),
        .i_sensor_code              (sensor_code),
        .i_low_index_afc_enable     (afc_en),
        .o_temp_conv_active         (conv_active),
        .o_rx_inhibit               (rx_inhibit),
        .o_tune_cfg                 (tune_cfg),
        .o_high_sensitivity         (high_sens),
        .o_fading_improved          (fading_imp),
        .o_low_index_freq_offset_hz (offset_hz)
    );

    spi_host_model i_spi_host_model (
        .o_sck   (spi_sck),
        .o_nss_n (spi_nss_n),
        .o_mosi  (spi_mosi),
        .i_miso  (spi_miso)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge spi_sck) begin
        check(24'(miso_oe_n), 24'h00_0000, "miso enable in frame");
    end

    always @(negedge core_clk) begin
        cycles++;
        if (conv_active === 1'b1) begin
            active_cycles++;
        end
        if (cycles == 20000) begin
            n_errors++;
            results();
        end
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic rd_chk(input logic [6:0] addr, input logic [7:0] exp);
        logic [15:0] d;
        i_spi_host_model.xfer({1'b0, addr}, 16'h0000, 16, d);
        check(24'(d[7:0]), 24'(exp), "register read");
        check(24'(miso_oe_n), 24'h00_0001, "miso released");
        @(negedge core_clk);
    endtask : rd_chk

    task automatic wr(input logic [6:0] addr, input logic [7:0] data);
        logic [15:0] d;
        i_spi_host_model.xfer({1'b1, addr}, {data, 8'h00}, 16, d);
        // let the write cross into the core domain
        repeat (8) @(negedge core_clk);
    endtask : wr

    task automatic results;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    initial begin
        reset_n     = 1'b0; // power-on reset, pin left to the device
        sensor_code = 8'hA5;
        afc_en      = 1'b0;
        repeat (4) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (10) @(negedge core_clk); // shortened wait for ready
        check(tune_cfg, {LNA_RST, DAGC_RST, AFC_RST}, "config after reset");
        rd_chk(ADDR_AFC_OFFSET, 8'h00);
        rd_chk(ADDR_TEMP_CTL, 8'h01);
        $display("test reset values done");

        for (int i = 0; i < 5; i++) begin
            wr((i < 2) ? ADDR_LNA_SEL : ADDR_FADING_SEL, codes[i]);
            rd_chk((i < 2) ? ADDR_LNA_SEL : ADDR_FADING_SEL, codes[i]);
            check(24'(high_sens), 24'(i == 0), "sensitivity flag");
            check(24'(fading_imp), 24'(i == 2 || i == 3), "fading flag");
            check(24'((i < 2) ? tune_cfg.lna : tune_cfg.dagc), 24'(codes[i]), "cfg field");
        end
        $display("test tuning codes done");

        afc_en = 1'b1;
        wr(ADDR_AFC_OFFSET, 8'hFF);
        rd_chk(ADDR_AFC_OFFSET, 8'hFF);
        check(24'(offset_hz), 24'(255 * 488), "offset enabled");
        afc_en = 1'b0;
        repeat (4) @(negedge core_clk);
        check(24'(offset_hz), 24'h00_0000, "offset disabled");
        $display("test afc offset done");

        wr(ADDR_TEMP_RESULT, 8'h3C);
        rd_chk(ADDR_TEMP_RESULT, RESULT_RST);
        wr(7'h60, 8'hFF);
        rd_chk(7'h60, 8'h00);
        $display("test refused writes done");

        active_cycles = 0;
        wr(ADDR_TEMP_CTL, 8'h08);
        check(24'(conv_active), 24'h00_0001, "conversion active");
        check(24'(rx_inhibit), 24'h00_0001, "receive inhibit");
        wr(ADDR_TEMP_CTL, 8'h08);
        rd_chk(ADDR_TEMP_CTL, 8'h05);
        for (int k = 0; k < 3000 && conv_active !== 1'b0; k++) begin
            @(negedge core_clk);
        end
        check(24'(active_cycles), 24'(P_CONV), "conversion length");
        check(24'(rx_inhibit), 24'h00_0000, "inhibit released");
        rd_chk(ADDR_TEMP_CTL, 8'h01);
        rd_chk(ADDR_TEMP_RESULT, 8'hA5);
        i_spi_host_model.xfer({1'b0, ADDR_TEMP_CTL}, 16'h0000, 24, burst);
        check(24'(burst), 24'h00_01A5, "burst read");
        @(negedge core_clk);
        $display("test conversion done");

        reset_n = 1'b0; // shortened reset pulse
        repeat (4) @(negedge core_clk);
        check(tune_cfg, {LNA_RST, DAGC_RST, AFC_RST}, "config in reset");
        reset_n = 1'b1;
        repeat (10) @(negedge core_clk); // shortened wait
        rd_chk(ADDR_FADING_SEL, DAGC_RST);
        rd_chk(ADDR_AFC_OFFSET, AFC_RST);
        $display("test second reset done");
        results();
    end

endmodule : temp_sensor_test_regs_reset_tb
